// ===== verilog/sensor_power_reset_sequencer.sv
// Contract
// RL1: pll supply first, analog and pixel supplies up to 10 us later.
// RL2: then io supply, then core supply, each up to 10 us apart.
// RL3: pll supply never rises after any other supply.
// RL4: external input clock enabled only after the last supply is stable.
// RL5: hold hard reset low at least 1 ms after rails settle.
// RL6: after reset release wait 850000 external clocks of initialization.
// RL7: after configuration writes wait 1 ms for pll lock before streaming.
// RL8: start streaming by writing one to bit 2 of sensor control.
// RL9: clear bit 2 of sensor control before removing power while streaming.
// RL10: device stops at end of row or frame after streaming is cleared.
// RL11: power down core, io, pixel and analog, then pll.
// RL12: keep supplies off at least 100 ms before the next power-up.
// RL13: refuse register writes until initialization ends; one state per step.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module sensor_power_reset_sequencer #(
  parameter logic [19:0] RESET_HOLD_CYC = sensor_seq_pkg::RESET_HOLD_CYC,
  parameter logic [19:0] INIT_EXTERNAL_INPUT_CLOCK_CNT = sensor_seq_pkg::INIT_EXTERNAL_INPUT_CLOCK_CNT,
  parameter logic [19:0] PLL_LOCK_CYC = sensor_seq_pkg::PLL_LOCK_CYC,
  parameter logic [19:0] STOP_WAIT_CYC = sensor_seq_pkg::STOP_WAIT_CYC,
  parameter logic [19:0] COOLDOWN_CYC = sensor_seq_pkg::COOLDOWN_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic supplies_stable,
  output sensor_seq_pkg::supply_en_t supply_en,
  output logic external_input_clock,
  output logic sensor_reset_n,
  output logic sensor_wr_valid,
  output sensor_seq_pkg::sensor_wr_t sensor_wr,
  input wire logic sensor_wr_ready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sensor_seq_pkg::state_t state_r, state_nxt;
  logic [1:0] ctrl_r;
  logic [15:0] ctrlval_r;
  logic refused_r;
  logic sw_pend_r;
  sensor_seq_pkg::sensor_wr_t sw_req_r;
  logic fsm_owner_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic [31:0] merged;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic ext_en_nxt;
  logic ext_rise;
  logic tmr_load, tmr_tick, tmr_done;
  logic [19:0] tmr_val;
  logic fsm_wr_req;
  logic wr_done, sw_done, fsm_done;
  logic power_on, stream_on, wr_open;
  logic [15:0] stream_word;

  assign power_on = ctrl_r[sensor_seq_pkg::CTRL_POWER_BIT];
  assign stream_on = ctrl_r[sensor_seq_pkg::CTRL_STREAM_BIT];
  // software writes are refused unless the state is S_READY or S_STREAMING
  assign wr_open = (state_r == sensor_seq_pkg::S_READY)
                || (state_r == sensor_seq_pkg::S_STREAMING); // [RL13]
  assign wr_done = sensor_wr_valid && sensor_wr_ready;
  assign fsm_done = wr_done && fsm_owner_r;
  assign sw_done = wr_done && !fsm_owner_r;
  assign stream_word = ctrlval_r;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign do_write = aw_hold_r && w_hold_r && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_hold_r <= 1'b1;
      awaddr_r <= awaddr;
    end else if (do_write) begin
      awready <= 1'b1;
      aw_hold_r <= 1'b0;
    end else begin
      awready <= !aw_hold_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_hold_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_hold_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (do_write) begin
      wready <= 1'b1;
      w_hold_r <= 1'b0;
    end else begin
      wready <= !w_hold_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= sensor_seq_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      case (awaddr_r)
        sensor_seq_pkg::CTRL_OFF, sensor_seq_pkg::STATUS_OFF,
        sensor_seq_pkg::SWR_OFF, sensor_seq_pkg::CTRLVAL_OFF: bresp <= sensor_seq_pkg::RESP_OKAY;
        default: bresp <= sensor_seq_pkg::RESP_DECERR;
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // byte lanes not strobed keep their old contents
  always_comb begin
    case (awaddr_r)
      sensor_seq_pkg::CTRL_OFF: merged = {30'h00000000, ctrl_r};
      sensor_seq_pkg::CTRLVAL_OFF: merged = {16'h0000, ctrlval_r};
      sensor_seq_pkg::SWR_OFF: merged = sw_req_r;
      default: merged = 32'h00000000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (wstrb_r[i]) begin
        merged[8*i +: 8] = wdata_r[8*i +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // controller registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= sensor_seq_pkg::CTRL_RST;
      ctrlval_r <= sensor_seq_pkg::CTRLVAL_RST;
    end else if (do_write && awaddr_r == sensor_seq_pkg::CTRL_OFF) begin
      ctrl_r <= merged[1:0];
    end else if (do_write && awaddr_r == sensor_seq_pkg::CTRLVAL_OFF) begin
      ctrlval_r <= merged[15:0];
    end
  end

  // a refused write leaves a sticky flag; the next accepted one clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_pend_r <= 1'b0;
      sw_req_r <= '0;
      refused_r <= 1'b0;
    end else begin
      if (sw_done) sw_pend_r <= 1'b0;
      if (do_write && awaddr_r == sensor_seq_pkg::SWR_OFF) begin
        if (wr_open && (!sw_pend_r || sw_done)) begin
          sw_pend_r <= 1'b1;
          sw_req_r <= merged;
          refused_r <= 1'b0;
        end else begin
          refused_r <= 1'b1; // [RL13]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (araddr)
      sensor_seq_pkg::CTRL_OFF: rd_mux = {30'h00000000, ctrl_r};
      sensor_seq_pkg::STATUS_OFF: rd_mux = {14'h0000, sw_pend_r, refused_r, state_r};
      sensor_seq_pkg::SWR_OFF: rd_mux = sw_req_r;
      sensor_seq_pkg::CTRLVAL_OFF: rd_mux = {16'h0000, ctrlval_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= sensor_seq_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? sensor_seq_pkg::RESP_OKAY : sensor_seq_pkg::RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // ----------------------------------------------------------------
  // sequencing state machine
  // ----------------------------------------------------------------
  assign fsm_wr_req = (state_r == sensor_seq_pkg::S_STR_ON
                    || state_r == sensor_seq_pkg::S_STR_OFF) && !sensor_wr_valid;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sensor_seq_pkg::S_OFF:
        if (power_on) state_nxt = sensor_seq_pkg::S_PU_PLL; // [RL3]
      sensor_seq_pkg::S_PU_PLL:
        if (!power_on) state_nxt = sensor_seq_pkg::S_PD_CORE;
        else if (tmr_done) state_nxt = sensor_seq_pkg::S_PU_ANA; // [RL1]
      sensor_seq_pkg::S_PU_ANA:
        if (!power_on) state_nxt = sensor_seq_pkg::S_PD_CORE;
        else if (tmr_done) state_nxt = sensor_seq_pkg::S_PU_IO; // [RL2]
      sensor_seq_pkg::S_PU_IO:
        if (!power_on) state_nxt = sensor_seq_pkg::S_PD_CORE;
        else if (tmr_done) state_nxt = sensor_seq_pkg::S_PU_CORE; // [RL2]
      sensor_seq_pkg::S_PU_CORE:
        if (!power_on) state_nxt = sensor_seq_pkg::S_PD_CORE;
        else if (supplies_stable) state_nxt = sensor_seq_pkg::S_RST_HOLD; // [RL4]
      sensor_seq_pkg::S_RST_HOLD:
        if (!power_on) state_nxt = sensor_seq_pkg::S_PD_CORE;
        else if (tmr_done) state_nxt = sensor_seq_pkg::S_INIT; // [RL5]
      sensor_seq_pkg::S_INIT:
        if (!power_on) state_nxt = sensor_seq_pkg::S_PD_CORE;
        else if (tmr_done) state_nxt = sensor_seq_pkg::S_READY; // [RL6]
      sensor_seq_pkg::S_READY:
        if (!power_on) state_nxt = sensor_seq_pkg::S_PD_CORE;
        else if (stream_on && tmr_done && !sw_pend_r && !sensor_wr_valid)
          state_nxt = sensor_seq_pkg::S_STR_ON; // [RL7]
      sensor_seq_pkg::S_STR_ON:
        if (fsm_done) state_nxt = sensor_seq_pkg::S_STREAMING; // [RL8]
      sensor_seq_pkg::S_STREAMING:
        if ((!power_on || !stream_on) && !sw_pend_r && !sensor_wr_valid)
          state_nxt = sensor_seq_pkg::S_STR_OFF; // [RL9]
      sensor_seq_pkg::S_STR_OFF:
        if (fsm_done) state_nxt = sensor_seq_pkg::S_STOP_WAIT; // [RL9]
      sensor_seq_pkg::S_STOP_WAIT:
        // no standby pin: allow a row or frame to drain for a fixed time
        if (tmr_done) begin
          state_nxt = power_on ? sensor_seq_pkg::S_READY : sensor_seq_pkg::S_PD_CORE; // [RL10]
        end
      sensor_seq_pkg::S_PD_CORE:
        if (tmr_done) state_nxt = sensor_seq_pkg::S_PD_IO; // [RL11]
      sensor_seq_pkg::S_PD_IO:
        if (tmr_done) state_nxt = sensor_seq_pkg::S_PD_ANA; // [RL11]
      sensor_seq_pkg::S_PD_ANA:
        if (tmr_done) state_nxt = sensor_seq_pkg::S_COOL; // [RL11]
      sensor_seq_pkg::S_COOL:
        if (tmr_done) state_nxt = sensor_seq_pkg::S_OFF; // [RL12]
      default:
        state_nxt = sensor_seq_pkg::S_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= sensor_seq_pkg::S_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // timer is loaded on the edge that enters a timed state
  always_comb begin
    tmr_load = 1'b0;
    tmr_val = sensor_seq_pkg::STEP_CYC - 20'h00001; // [RL1]
    if (state_nxt != state_r) begin
      case (state_nxt)
        sensor_seq_pkg::S_PU_PLL, sensor_seq_pkg::S_PU_ANA, sensor_seq_pkg::S_PU_IO,
        sensor_seq_pkg::S_PD_CORE, sensor_seq_pkg::S_PD_IO, sensor_seq_pkg::S_PD_ANA:
          tmr_load = 1'b1;
        sensor_seq_pkg::S_RST_HOLD: begin
          tmr_load = 1'b1;
          tmr_val = RESET_HOLD_CYC; // [RL5]
        end
        sensor_seq_pkg::S_INIT: begin
          tmr_load = 1'b1;
          tmr_val = INIT_EXTERNAL_INPUT_CLOCK_CNT; // [RL6]
        end
        sensor_seq_pkg::S_READY: begin
          tmr_load = 1'b1;
          tmr_val = PLL_LOCK_CYC; // [RL7]
        end
        sensor_seq_pkg::S_STOP_WAIT: begin
          tmr_load = 1'b1;
          tmr_val = STOP_WAIT_CYC;
        end
        sensor_seq_pkg::S_COOL: begin
          tmr_load = 1'b1;
          tmr_val = COOLDOWN_CYC; // [RL12]
        end
        default: tmr_load = 1'b0;
      endcase
    end else if (state_r == sensor_seq_pkg::S_READY && sw_done) begin
      // every configuration write completed in S_READY restarts the lock wait
      tmr_load = 1'b1;
      tmr_val = PLL_LOCK_CYC; // [RL7]
    end
  end

  // initialization is counted in external clocks, everything else in aclk
  assign tmr_tick = (state_r == sensor_seq_pkg::S_INIT) ? ext_rise : 1'b1; // [RL6]

  seq_timer #(
    .W(sensor_seq_pkg::TMR_W)
  ) u_timer (
    .clk(aclk),
    .rst_n(aresetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .tick(tmr_tick),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // supply, reset and clock pins
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_en <= '0;
    end else begin
      case (state_nxt)
        sensor_seq_pkg::S_OFF, sensor_seq_pkg::S_COOL:
          supply_en <= '0;
        sensor_seq_pkg::S_PU_PLL, sensor_seq_pkg::S_PD_ANA:
          supply_en <= '{pll: 1'b1, default: 1'b0}; // [RL3]
        sensor_seq_pkg::S_PU_ANA, sensor_seq_pkg::S_PD_IO:
          supply_en <= '{pll: 1'b1, analog: 1'b1, pixel: 1'b1, default: 1'b0}; // [RL1]
        sensor_seq_pkg::S_PU_IO, sensor_seq_pkg::S_PD_CORE:
          supply_en <= '{core: 1'b0, default: 1'b1}; // [RL2]
        default:
          supply_en <= '{default: 1'b1}; // [RL2]
      endcase
    end
  end

  // reset is held low until initialization starts and again at power-down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensor_reset_n <= 1'b0;
    end else begin
      sensor_reset_n <= state_nxt inside {sensor_seq_pkg::S_INIT, sensor_seq_pkg::S_READY,
        sensor_seq_pkg::S_STR_ON, sensor_seq_pkg::S_STREAMING,
        sensor_seq_pkg::S_STR_OFF, sensor_seq_pkg::S_STOP_WAIT}; // [RL5]
    end
  end

  // divide-by-two, 5 MHz; gated by the next state so it stops with the core supply
  assign ext_en_nxt = state_nxt inside {sensor_seq_pkg::S_RST_HOLD, sensor_seq_pkg::S_INIT,
    sensor_seq_pkg::S_READY, sensor_seq_pkg::S_STR_ON, sensor_seq_pkg::S_STREAMING,
    sensor_seq_pkg::S_STR_OFF, sensor_seq_pkg::S_STOP_WAIT}; // [RL4]
  assign ext_rise = ext_en_nxt && !external_input_clock;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_input_clock <= 1'b0;
    end else begin
      external_input_clock <= ext_rise; // [RL4]
    end
  end

  // ----------------------------------------------------------------
  // sensor register write port
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensor_wr_valid <= 1'b0;
      sensor_wr <= '0;
      fsm_owner_r <= 1'b0;
    end else if (wr_done) begin
      sensor_wr_valid <= 1'b0;
    end else if (fsm_wr_req) begin
      sensor_wr_valid <= 1'b1;
      fsm_owner_r <= 1'b1;
      sensor_wr.addr <= sensor_seq_pkg::SENSOR_CONTROL_ADDR;
      sensor_wr.data <= stream_word;
      sensor_wr.data[sensor_seq_pkg::STREAM_BIT] <=
        (state_r == sensor_seq_pkg::S_STR_ON); // [RL8] [RL9]
    end else if (sw_pend_r && !sensor_wr_valid) begin
      sensor_wr_valid <= 1'b1;
      fsm_owner_r <= 1'b0;
      sensor_wr <= sw_req_r; // [RL13]
    end
  end

endmodule

// ===== inc/sensor_seq_pkg.sv
package sensor_seq_pkg;

  // ------------------------------
  // timing figures and derived cycle counts
  // ------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TMR_W = 20;
  localparam int SUPPLY_STEP_US = 10;
  localparam int RESET_HOLD_MS = 1;
  localparam int PLL_LOCK_MS = 1;
  localparam int COOLDOWN_MS = 100;
  localparam int STOP_WAIT_MS = 1;
  localparam int INIT_EXTCLKS = 850000;
  // longest spacing rounds down, least times round up
  localparam logic [TMR_W-1:0] STEP_CYC = TMR_W'((SUPPLY_STEP_US * 1000) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] RESET_HOLD_CYC =
    TMR_W'((RESET_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PLL_LOCK_CYC =
    TMR_W'((PLL_LOCK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] COOLDOWN_CYC =
    TMR_W'((COOLDOWN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] STOP_WAIT_CYC =
    TMR_W'((STOP_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] INIT_EXTERNAL_INPUT_CLOCK_CNT = TMR_W'(INIT_EXTCLKS);

  // ------------------------------
  // register map of this controller
  // ------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] SWR_OFF = 8'h08;
  localparam logic [7:0] CTRLVAL_OFF = 8'h0C;
  localparam int CTRL_POWER_BIT = 0;
  localparam int CTRL_STREAM_BIT = 1;
  localparam int STAT_REFUSED_BIT = 16;
  localparam int STAT_PEND_BIT = 17;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] CTRLVAL_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ------------------------------
  // sensor side
  // ------------------------------
  localparam logic [15:0] SENSOR_CONTROL_ADDR = 16'h301A;
  localparam int STREAM_BIT = 2;

  typedef enum logic [15:0] {
    S_OFF = 16'h0001,
    S_PU_PLL = 16'h0002,
    S_PU_ANA = 16'h0004,
    S_PU_IO = 16'h0008,
    S_PU_CORE = 16'h0010,
    S_RST_HOLD = 16'h0020,
    S_INIT = 16'h0040,
    S_READY = 16'h0080,
    S_STR_ON = 16'h0100,
    S_STREAMING = 16'h0200,
    S_STR_OFF = 16'h0400,
    S_STOP_WAIT = 16'h0800,
    S_PD_CORE = 16'h1000,
    S_PD_IO = 16'h2000,
    S_PD_ANA = 16'h4000,
    S_COOL = 16'h8000
  } state_t;

  typedef struct packed {
    logic pll;
    logic analog;
    logic pixel;
    logic io;
    logic core;
  } supply_en_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } sensor_wr_t;

endpackage

// ===== verilog/seq_timer.sv
`timescale 1ns/1ps
module seq_timer #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  output logic done
);

  logic [W-1:0] cnt_r;

  // load wins over a tick in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (tick && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign done = (cnt_r == '0);

endmodule

// ===== sim/sensor_seq_sva.sv
`timescale 1ns/1ps
module sensor_seq_sva #(
  parameter logic [19:0] RESET_HOLD_CYC = '0,
  parameter logic [19:0] INIT_EXTERNAL_INPUT_CLOCK_CNT = '0,
  parameter logic [19:0] PLL_LOCK_CYC = '0,
  parameter logic [19:0] COOLDOWN_CYC = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supplies_stable,
  input sensor_seq_pkg::supply_en_t supply_en,
  input wire logic external_input_clock,
  input wire logic sensor_reset_n,
  input wire logic sensor_wr_valid,
  input sensor_seq_pkg::sensor_wr_t sensor_wr,
  input wire logic sensor_wr_ready
);
  int hold_c, init_c, lock_c, off_c;
  logic ext_q, str_r, take, ctl_wr;
  assign take = sensor_wr_valid && sensor_wr_ready;
  assign ctl_wr = take && sensor_wr.addr == sensor_seq_pkg::SENSOR_CONTROL_ADDR;
  always_ff @(posedge aclk) begin
    if (!aresetn || sensor_reset_n || !supplies_stable) hold_c <= 0;
    else hold_c <= hold_c + 1;
  end
  always_ff @(posedge aclk) begin
    ext_q <= external_input_clock;
    if (!sensor_reset_n) init_c <= 0;
    else if (external_input_clock && !ext_q) init_c <= init_c + 1;
  end
  always_ff @(posedge aclk) begin
    if (!sensor_reset_n || (take && !ctl_wr)) lock_c <= 0;
    else lock_c <= lock_c + 1;
  end
  // reset counts as a finished cooldown
  always_ff @(posedge aclk) begin
    if (!aresetn) off_c <= int'(COOLDOWN_CYC);
    else if (supply_en.pll) off_c <= 0;
    else off_c <= off_c + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) str_r <= 1'h0;
    else if (ctl_wr) str_r <= sensor_wr.data[sensor_seq_pkg::STREAM_BIT];
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_str_on;
    $rose(sensor_wr_valid) && sensor_wr.addr == sensor_seq_pkg::SENSOR_CONTROL_ADDR
      && sensor_wr.data[sensor_seq_pkg::STREAM_BIT];
  endsequence
  sequence s_stall;
    sensor_wr_valid && !sensor_wr_ready;
  endsequence
  chk_supply_order: assert property (
    (!supply_en.core || supply_en.io) && (!supply_en.io || supply_en.analog)
    && (!supply_en.analog || supply_en.pll) && supply_en.analog == supply_en.pixel)
    else $error("supply order broken");
  chk_analog_step: assert property (
    $rose(supply_en.pll) |-> ##[0:100] (supply_en.analog || !supply_en.pll))
    else $error("analog supply late");
  chk_io_step: assert property (
    $rose(supply_en.analog) |-> ##[0:100] (supply_en.io || !supply_en.analog))
    else $error("io supply late");
  chk_core_step: assert property (
    $rose(supply_en.io) |-> ##[0:100] (supply_en.core || !supply_en.io))
    else $error("core supply late");
  chk_clk_gate: assert property (
    external_input_clock |-> supply_en.core && supplies_stable)
    else $error("clock before supplies stable");
  chk_reset_hold: assert property (
    $rose(sensor_reset_n) |-> hold_c >= int'(RESET_HOLD_CYC))
    else $error("hard reset too short");
  chk_init_wait: assert property (
    $rose(sensor_wr_valid) |-> init_c >= int'(INIT_EXTERNAL_INPUT_CLOCK_CNT))
    else $error("write before init done");
  chk_lock_wait: assert property (
    s_str_on |-> lock_c >= int'(PLL_LOCK_CYC))
    else $error("stream before pll lock");
  chk_stop_first: assert property (
    $fell(supply_en.core) |-> !str_r)
    else $error("power removed while streaming");
  chk_cool_off: assert property (
    $rose(supply_en.pll) |-> off_c >= int'(COOLDOWN_CYC))
    else $error("supplies off too briefly");
  chk_wr_hold: assert property (
    s_stall |=> sensor_wr_valid && $stable(sensor_wr))
    else $error("sensor write dropped");
endmodule
bind sensor_power_reset_sequencer sensor_seq_sva #(.RESET_HOLD_CYC(RESET_HOLD_CYC),
  .INIT_EXTERNAL_INPUT_CLOCK_CNT(INIT_EXTERNAL_INPUT_CLOCK_CNT), .PLL_LOCK_CYC(PLL_LOCK_CYC),
  .COOLDOWN_CYC(COOLDOWN_CYC)) u_sva (.aclk, .aresetn, .supplies_stable, .supply_en,
  .external_input_clock, .sensor_reset_n, .sensor_wr_valid, .sensor_wr, .sensor_wr_ready);

// ===== sim/sensor_model.sv
`timescale 1ns/1ps
module sensor_model #(
  parameter int INIT_CNT = 10, ROW_CYC = 8,
  parameter logic [15:0] CTRL_RST = 16'h0000
) (
  input wire logic clk,
  input wire logic slow,
  input sensor_seq_pkg::supply_en_t supply_en,
  input wire logic ext_clk,
  input wire logic reset_n,
  input wire logic wr_valid,
  input sensor_seq_pkg::sensor_wr_t wr,
  output logic wr_ready,
  output logic stable,
  output logic [15:0] ctrl,
  output sensor_seq_pkg::sensor_wr_t last_wr,
  output logic standby,
  output logic [7:0] err_cnt
);
  int stab_c, ini_c, wait_c, row_c, err;
  logic ext_q, up, take;
  assign up = &supply_en;
  assign stable = stab_c >= 4;
  assign err_cnt = 8'(err);
  // refuses writes until init has counted out
  assign wr_ready = wr_valid && ini_c >= INIT_CNT && wait_c >= (slow ? 3 : 0);
  assign take = wr_valid && wr_ready;
  always @(posedge clk) begin
    ext_q <= ext_clk;
    stab_c <= up ? stab_c + int'(stab_c < 4) : 0;
    wait_c <= (wr_valid && !take) ? wait_c + 1 : 0;
    if (wr_valid && (ini_c < INIT_CNT || !up)) err <= err + 1;
    if (!reset_n) ini_c <= 0;
    else if (ext_clk && !ext_q) ini_c <= ini_c + 1;
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      ctrl <= CTRL_RST;
      standby <= 1'h1;
      row_c <= 0;
    end else if (take && wr.addr == sensor_seq_pkg::SENSOR_CONTROL_ADDR) begin
      ctrl <= wr.data;
      if (wr.data[sensor_seq_pkg::STREAM_BIT]) standby <= 1'h0;
      else row_c <= ROW_CYC;
    end else if (row_c > 0) begin
      row_c <= row_c - 1;
      if (row_c == 1) standby <= 1'h1;
    end
    if (take) last_wr <= wr;
  end
endmodule

// ===== sim/sensor_power_reset_sequencer_tb.sv
`timescale 1ns/1ps
module sensor_power_reset_sequencer_tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] resp;} row_t;
  localparam logic [1:0] OK = sensor_seq_pkg::RESP_OKAY;
  localparam logic [1:0] DE = sensor_seq_pkg::RESP_DECERR;
  row_t rows [10] = '{'{1'h0, 8'h0C, 32'h0, OK}, '{1'h0, 8'h00, 32'h0, OK},
    '{1'h0, 8'h04, 32'h1, OK}, '{1'h1, 8'h0C, 32'h1230, OK}, '{1'h0, 8'h0C, 32'h1230, OK},
    '{1'h1, 8'h04, 32'hFFFF, OK}, '{1'h0, 8'h10, 32'h0, DE}, '{1'h1, 8'h20, 32'h5, DE},
    '{1'h1, 8'h08, 32'h30000005, OK}, '{1'h0, 8'h04, 32'h10001, OK}};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, stable, ext_clk, srst_n, wv, wrdy, stby;
  logic [15:0] mctl;
  logic [7:0] err;
  sensor_seq_pkg::supply_en_t supply_en;
  sensor_seq_pkg::sensor_wr_t sw, last;
  int n_fail, checks;
  sensor_power_reset_sequencer #(.RESET_HOLD_CYC(20'h14), .INIT_EXTERNAL_INPUT_CLOCK_CNT(20'hA),
    .PLL_LOCK_CYC(20'h14), .STOP_WAIT_CYC(20'h14), .COOLDOWN_CYC(20'h1E)) DUT (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .supplies_stable(stable),
    .supply_en, .external_input_clock(ext_clk), .sensor_reset_n(srst_n), .sensor_wr_valid(wv),
    .sensor_wr(sw), .sensor_wr_ready(wrdy));
  sensor_model u_model (.clk(aclk), .slow, .supply_en, .ext_clk(ext_clk),
    .reset_n(srst_n), .wr_valid(wv), .wr(sw), .wr_ready(wrdy), .stable(stable),
    .ctrl(mctl), .last_wr(last), .standby(stby), .err_cnt(err));
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  task automatic summarize();
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    bready <= 1'h0;
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask
  task automatic wait_st(input logic [31:0] s);
    int n = 0;
    do begin
      rd(sensor_seq_pkg::STATUS_OFF);
      n++;
    end while (d !== s && n < 400);
    chk("status", s, d);
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    summarize();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    chk("reset pins", 32'h0, {24'h0, supply_en, ext_clk, srst_n, wv});
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a);
      if (!rows[i].wr) chk("rdata", rows[i].d, d);
      chk("resp", {30'h0, rows[i].resp}, {30'h0, r});
    end
    wr(sensor_seq_pkg::CTRL_OFF, 32'h1);
    wait_st(32'h10080);
    chk("supply_en", 32'h1F, {27'h0, supply_en});
    chk("sensor_reset_n", 32'h1, {31'h0, srst_n});
    slow <= 1'h1;
    wr(sensor_seq_pkg::SWR_OFF, 32'h30280042);
    wait_st(32'h80);
    chk("last write", 32'h30280042, last);
    wr(sensor_seq_pkg::CTRL_OFF, 32'h3);
    wait_st(32'h200);
    chk("sensor control", 32'h1234, {16'h0, mctl});
    wr(sensor_seq_pkg::CTRL_OFF, 32'h0);
    wait_st(32'h800);
    chk("sensor control", 32'h1230, {16'h0, mctl});
    repeat (8) @(posedge aclk);
    chk("standby", 32'h1, {31'h0, stby});
    wait_st(32'h1);
    chk("supply_en", 32'h0, {27'h0, supply_en});
    chk("model errors", 32'h0, {24'h0, err});
    // power up straight after cooldown, then cut it short by reset
    wr(sensor_seq_pkg::CTRL_OFF, 32'h1);
    repeat (150) @(posedge aclk);
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    chk("reset pins", 32'h0, {24'h0, supply_en, ext_clk, srst_n, wv});
    aresetn <= 1'h1;
    rd(sensor_seq_pkg::CTRL_OFF);
    chk("ctrl reset", 32'h0, d);
    summarize();
  end
endmodule
